/* File: include/pbfws_pkg.sv */
/*
   Shared constants of the peripheral flash bus wait-state controller:
   register offsets, field positions, reset values, wait counts, responses.
   Assumes a 32-bit AXI4-Lite register port and a single 50 MHz clock.
*/
// Operation
// R1: Bits 4:2 codes 0-3 give 5/9/13/17 waits
// R2: Other address-to-data codes give 21 waits
// R3: Bits 8:6 codes 0-4 give 3/6/10/14/18 waits
// R4: Other recovery codes give 22 waits
// R5: Each flash bank keeps its own timing fields
// R6: Count address waits, strobe, then recovery waits
package pbfws_pkg;

   localparam int unsigned PBFWS_ADDR_W = 12;
   localparam int unsigned PBFWS_DATA_W = 32;
   localparam int unsigned PBFWS_STRB_W = 4;
   localparam int unsigned PBFWS_WAIT_W = 5;
   localparam int unsigned PBFWS_CODE_W = 3;

   // Register byte offsets
   localparam logic [11:0] PBFWS_OFF_BANK0 = 12'h000;
   localparam logic [11:0] PBFWS_OFF_BANK1 = 12'h004;
   localparam logic [11:0] PBFWS_OFF_STATUS = 12'h008;

   // Field positions inside each bank register
   localparam int unsigned PBFWS_AD_LSB = 2;
   localparam int unsigned PBFWS_RC_LSB = 6;

   // Both codes at 3'h7 so a bank starts on the slowest profile
   localparam logic [31:0] PBFWS_BANK_RESET = 32'h000001dc;

   // Status register layout
   localparam int unsigned PBFWS_STAT_BUSY = 0;
   localparam int unsigned PBFWS_STAT_BANK = 1;
   localparam int unsigned PBFWS_STAT_CNT_LSB = 8;

   // Address-to-data wait counts
   localparam logic [4:0] PBFWS_AD_WAIT_0 = 5'h05;
   localparam logic [4:0] PBFWS_AD_WAIT_1 = 5'h09;
   localparam logic [4:0] PBFWS_AD_WAIT_2 = 5'h0d;
   localparam logic [4:0] PBFWS_AD_WAIT_3 = 5'h11;
   localparam logic [4:0] PBFWS_AD_WAIT_DEF = 5'h15;

   // Recovery wait counts
   localparam logic [4:0] PBFWS_RC_WAIT_0 = 5'h03;
   localparam logic [4:0] PBFWS_RC_WAIT_1 = 5'h06;
   localparam logic [4:0] PBFWS_RC_WAIT_2 = 5'h0a;
   localparam logic [4:0] PBFWS_RC_WAIT_3 = 5'h0e;
   localparam logic [4:0] PBFWS_RC_WAIT_4 = 5'h12;
   localparam logic [4:0] PBFWS_RC_WAIT_DEF = 5'h16;

   // Bus responses
   localparam logic [1:0] PBFWS_RESP_OKAY = 2'h0;
   localparam logic [1:0] PBFWS_RESP_SLVERR = 2'h2;

endpackage

/* File: verilog/pbfws_wait_lut.sv */
/*
   Decodes the two timing codes of one flash bank into wait counts.
   Purely combinational; the caller registers whatever it uses.
*/
`timescale 1ns/1ps
module pbfws_wait_lut (
   input wire logic [2:0] ad_code_i,
   input wire logic [2:0] rc_code_i,
   output logic [4:0] ad_waits_o,
   output logic [4:0] rc_waits_o
);

   always_comb begin
      case (ad_code_i)
         3'h0: ad_waits_o = pbfws_pkg::PBFWS_AD_WAIT_0; // see R1
         3'h1: ad_waits_o = pbfws_pkg::PBFWS_AD_WAIT_1; // see R1
         3'h2: ad_waits_o = pbfws_pkg::PBFWS_AD_WAIT_2; // see R1
         3'h3: ad_waits_o = pbfws_pkg::PBFWS_AD_WAIT_3; // see R1
         default: ad_waits_o = pbfws_pkg::PBFWS_AD_WAIT_DEF; // see R2
      endcase
   end

   always_comb begin
      case (rc_code_i)
         3'h0: rc_waits_o = pbfws_pkg::PBFWS_RC_WAIT_0; // see R3
         3'h1: rc_waits_o = pbfws_pkg::PBFWS_RC_WAIT_1; // see R3
         3'h2: rc_waits_o = pbfws_pkg::PBFWS_RC_WAIT_2; // see R3
         3'h3: rc_waits_o = pbfws_pkg::PBFWS_RC_WAIT_3; // see R3
         3'h4: rc_waits_o = pbfws_pkg::PBFWS_RC_WAIT_4; // see R3
         default: rc_waits_o = pbfws_pkg::PBFWS_RC_WAIT_DEF; // see R4
      endcase
   end

endmodule

/* File: verilog/pbfws_top.sv */
/*
   Peripheral flash bus wait-state controller: two bank timing registers
   and a status register behind an AXI4-Lite slave, plus the access
   sequencer that paces address strobe, data strobe and recovery.
   Assumes the request port and the bus run on mclk_i; no synchronisers.
*/
`timescale 1ns/1ps
module pbfws_top (
   input wire logic mclk_i,
   input wire logic reset_i,
   // AXI4-Lite slave
   input wire logic [11:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   input wire logic [11:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   // Access request from the bus unit
   input wire logic req_valid_i,
   input wire logic req_bank_i,
   output logic req_ready_o,
   output logic req_done_o,
   // Flash bus strobes
   output logic addr_strobe_o,
   output logic [1:0] bank_select_o,
   output logic data_strobe_o
);

   typedef enum logic [2:0] {
      PBFWS_IDLE,
      PBFWS_ADDR,
      PBFWS_WAIT,
      PBFWS_STROBE,
      PBFWS_RECOV
   } pbfws_phase_e;

   typedef struct packed {
      pbfws_phase_e phase;
      logic [31:0] bank0;
      logic [31:0] bank1;
      logic [4:0] cnt;
      logic [4:0] rc_load;
      logic bank;
      logic aw_held;
      logic [11:0] aw_addr;
      logic w_held;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic req_ready;
      logic req_done;
      logic addr_strobe;
      logic [1:0] bank_sel;
      logic data_strobe;
   } pbfws_state_s;

   pbfws_state_s st_reg;
   pbfws_state_s st_next;

   logic [4:0] ad_waits [2];
   logic [4:0] rc_waits [2];
   logic [31:0] bank_regs [2];

   assign bank_regs[0] = st_reg.bank0;
   assign bank_regs[1] = st_reg.bank1;

   // One decoder per bank so each bank runs its own profile
   for (genvar b = 0; b < 2; b++) begin : g_bank
      pbfws_wait_lut u_lut ( // see R5
         .ad_code_i(bank_regs[b][pbfws_pkg::PBFWS_AD_LSB +: pbfws_pkg::PBFWS_CODE_W]),
         .rc_code_i(bank_regs[b][pbfws_pkg::PBFWS_RC_LSB +: pbfws_pkg::PBFWS_CODE_W]),
         .ad_waits_o(ad_waits[b]),
         .rc_waits_o(rc_waits[b])
      );
   end

   function automatic logic [31:0] pbfws_merge(
      input logic [31:0] old_v,
      input logic [31:0] new_v,
      input logic [3:0] strb
   );
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[8*i +: 8] = new_v[8*i +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic [31:0] pbfws_status(input pbfws_state_s s);
      logic [31:0] v;
      v = 32'h00000000;
      v[pbfws_pkg::PBFWS_STAT_BUSY] = (s.phase != PBFWS_IDLE);
      v[pbfws_pkg::PBFWS_STAT_BANK] = s.bank;
      v[pbfws_pkg::PBFWS_STAT_CNT_LSB +: pbfws_pkg::PBFWS_WAIT_W] = s.cnt;
      return v;
   endfunction

   always_comb begin
      st_next = st_reg;
      st_next.req_done = 1'b0;
      st_next.addr_strobe = 1'b0;
      st_next.data_strobe = 1'b0;

      // Write channels are taken independently, in either order
      if (s_axi_awvalid_i && st_reg.awready) begin
         st_next.aw_held = 1'b1;
         st_next.aw_addr = s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && st_reg.wready) begin
         st_next.w_held = 1'b1;
         st_next.wdata = s_axi_wdata_i;
         st_next.wstrb = s_axi_wstrb_i;
      end
      if (st_reg.bvalid && s_axi_bready_i) begin
         st_next.bvalid = 1'b0;
      end
      if (st_reg.aw_held && st_reg.w_held && !st_reg.bvalid) begin
         st_next.aw_held = 1'b0;
         st_next.w_held = 1'b0;
         st_next.bvalid = 1'b1;
         st_next.bresp = pbfws_pkg::PBFWS_RESP_OKAY;
         // A change lands on the next access; one in flight keeps its counts
         case ({st_reg.aw_addr[11:2], 2'h0})
            pbfws_pkg::PBFWS_OFF_BANK0: begin
               st_next.bank0 = pbfws_merge(st_reg.bank0, st_reg.wdata, st_reg.wstrb); // see R5
            end
            pbfws_pkg::PBFWS_OFF_BANK1: begin
               st_next.bank1 = pbfws_merge(st_reg.bank1, st_reg.wdata, st_reg.wstrb); // see R5
            end
            pbfws_pkg::PBFWS_OFF_STATUS: begin
               st_next.bresp = pbfws_pkg::PBFWS_RESP_OKAY;
            end
            default: begin
               st_next.bresp = pbfws_pkg::PBFWS_RESP_SLVERR;
            end
         endcase
      end
      st_next.awready = !st_next.aw_held && !st_next.bvalid;
      st_next.wready = !st_next.w_held && !st_next.bvalid;

      // Read channel
      if (st_reg.rvalid && s_axi_rready_i) begin
         st_next.rvalid = 1'b0;
      end
      if (s_axi_arvalid_i && st_reg.arready) begin
         st_next.rvalid = 1'b1;
         st_next.rresp = pbfws_pkg::PBFWS_RESP_OKAY;
         case ({s_axi_araddr_i[11:2], 2'h0})
            pbfws_pkg::PBFWS_OFF_BANK0: begin
               st_next.rdata = st_reg.bank0;
            end
            pbfws_pkg::PBFWS_OFF_BANK1: begin
               st_next.rdata = st_reg.bank1;
            end
            pbfws_pkg::PBFWS_OFF_STATUS: begin
               st_next.rdata = pbfws_status(st_reg);
            end
            default: begin
               st_next.rdata = 32'h00000000;
               st_next.rresp = pbfws_pkg::PBFWS_RESP_SLVERR;
            end
         endcase
      end
      st_next.arready = !st_next.rvalid;

      // Access sequencer
      unique case (st_reg.phase)
         PBFWS_IDLE: begin
            if (req_valid_i && st_reg.req_ready) begin
               st_next.phase = PBFWS_ADDR;
               st_next.bank = req_bank_i;
               st_next.cnt = ad_waits[req_bank_i]; // see R5, R6
               st_next.rc_load = rc_waits[req_bank_i]; // see R5, R6
               st_next.addr_strobe = 1'b1;
               st_next.bank_sel = {req_bank_i, !req_bank_i};
               st_next.req_ready = 1'b0;
            end
         end
         PBFWS_ADDR: begin
            st_next.phase = PBFWS_WAIT;
         end
         PBFWS_WAIT: begin
            // Every count is at least one, so a cnt of 1 ends the wait
            if (st_reg.cnt == 5'h01) begin
               st_next.phase = PBFWS_STROBE; // see R6
               st_next.data_strobe = 1'b1;
               st_next.req_done = 1'b1;
            end else begin
               st_next.cnt = st_reg.cnt - 5'h01; // see R6
            end
         end
         PBFWS_STROBE: begin
            st_next.phase = PBFWS_RECOV;
            st_next.cnt = st_reg.rc_load; // see R6
            st_next.bank_sel = 2'h0;
         end
         PBFWS_RECOV: begin
            if (st_reg.cnt == 5'h01) begin
               st_next.phase = PBFWS_IDLE; // see R6
               st_next.req_ready = 1'b1;
            end else begin
               st_next.cnt = st_reg.cnt - 5'h01; // see R6
            end
         end
      endcase
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         st_reg <= '0;
         st_reg.phase <= PBFWS_IDLE;
         st_reg.bank0 <= pbfws_pkg::PBFWS_BANK_RESET;
         st_reg.bank1 <= pbfws_pkg::PBFWS_BANK_RESET;
         st_reg.awready <= 1'b1;
         st_reg.wready <= 1'b1;
         st_reg.arready <= 1'b1;
         st_reg.req_ready <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   assign s_axi_awready_o = st_reg.awready;
   assign s_axi_wready_o = st_reg.wready;
   assign s_axi_bresp_o = st_reg.bresp;
   assign s_axi_bvalid_o = st_reg.bvalid;
   assign s_axi_arready_o = st_reg.arready;
   assign s_axi_rdata_o = st_reg.rdata;
   assign s_axi_rresp_o = st_reg.rresp;
   assign s_axi_rvalid_o = st_reg.rvalid;
   assign req_ready_o = st_reg.req_ready;
   assign req_done_o = st_reg.req_done;
   assign addr_strobe_o = st_reg.addr_strobe;
   assign bank_select_o = st_reg.bank_sel;
   assign data_strobe_o = st_reg.data_strobe;

endmodule

/* File: bench/pbfws_top_sva.sv */
/* Checker for the flash wait-state controller, bound to its top.
   Assumes one clock and the synchronous active-high reset. */
`timescale 1ns/1ps
module pbfws_top_sva (
   input wire logic mclk_i,
   input wire logic reset_i,
   input wire logic s_axi_arvalid_i,
   input wire logic s_axi_arready_o,
   input wire logic s_axi_rvalid_o,
   input wire logic req_valid_i,
   input wire logic req_ready_o,
   input wire logic req_done_o,
   input wire logic addr_strobe_o,
   input wire logic [1:0] bank_select_o,
   input wire logic data_strobe_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (reset_i);
   // Shortest legal gaps; the ranges after them end at the default counts
   sequence addr_gap_s;
      (!data_strobe_o) [*5];
   endsequence
   sequence rec_gap_s;
      (!req_ready_o) [*3];
   endsequence
   accept_start_a:
   assert property ((req_valid_i && req_ready_o) |=> addr_strobe_o && !req_ready_o && $onehot(bank_select_o))
      else $error("access start wrong");
   strobe_pulse_a:
   assert property (addr_strobe_o |=> !addr_strobe_o) else $error("address strobe too long");
   addr_wait_a:
   assert property (addr_strobe_o |=> addr_gap_s ##[1:17] data_strobe_o) else $error("address wait out of range");
   done_pair_a:
   assert property (data_strobe_o == req_done_o) else $error("done apart from strobe");
   rec_min_a:
   assert property (data_strobe_o |=> rec_gap_s) else $error("recovery too short");
   rec_wait_a:
   assert property (data_strobe_o |=> rec_gap_s ##[1:20] req_ready_o) else $error("recovery too long");
   bank_drop_a:
   assert property (data_strobe_o |-> $onehot(bank_select_o) ##1 bank_select_o == 2'h0)
      else $error("bank select not released");
   read_answer_a:
   assert property ((s_axi_arvalid_i && s_axi_arready_o) |=> s_axi_rvalid_o && !s_axi_arready_o)
      else $error("read answer late");
endmodule
bind pbfws_top pbfws_top_sva u_sva (.mclk_i, .reset_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rvalid_o,
   .req_valid_i, .req_ready_o, .req_done_o, .addr_strobe_o, .bank_select_o, .data_strobe_o);

/* File: bench/pbfws_flash_model.sv */
/* Flash-side model: measures address-to-data waits and the bank used.
   Assumes strobes on mclk_i; the flash drives nothing back here. */
`timescale 1ns/1ps
module pbfws_flash_model (
   input wire logic mclk_i,
   input wire logic addr_strobe_i,
   input wire logic data_strobe_i,
   input wire logic [1:0] bank_select_i,
   output logic [7:0] ad_waits_o,
   output logic [1:0] bank_seen_o
);
   logic busy = 1'b0;
   logic [7:0] cnt = 8'h00;
   always @(posedge mclk_i) begin
      if (addr_strobe_i) begin
         busy <= 1'b1;
         cnt <= 8'h00;
         bank_seen_o <= bank_select_i;
      end else if (data_strobe_i) begin
         busy <= 1'b0;
         ad_waits_o <= cnt;
      end else if (busy) begin
         cnt <= cnt + 8'h01;
      end
   end
endmodule

/* File: bench/pbfws_top_tb.sv */
/* Bench for the flash wait-state controller: table of codes, then reset,
   unmapped and per-bank cases. Assumes one 50 MHz clock. */
`timescale 1ns/1ps
module pbfws_top_tb;
   typedef struct packed {logic b; logic [2:0] c; logic [4:0] n; logic [4:0] m;} pbfws_row_s;
   logic mclk_i = 1'b0, reset_i = 1'b1;
   logic [11:0] s_axi_awaddr_i = 12'h0, s_axi_araddr_i = 12'h0;
   logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o;
   logic [3:0] s_axi_wstrb_i = 4'h0;
   logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0, s_axi_arvalid_i = 1'b0;
   logic s_axi_rready_i = 1'b0, req_valid_i = 1'b0, req_bank_i = 1'b0;
   logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
   logic req_ready_o, req_done_o, addr_strobe_o, data_strobe_o;
   logic [1:0] s_axi_bresp_o, s_axi_rresp_o, bank_select_o, bank_seen;
   logic [7:0] ad_waits;
   int mismatches = 0, compares = 0;
   pbfws_row_s rows [8] = '{'{1'b0, 3'h0, 5'h05, 5'h03}, '{1'b1, 3'h1, 5'h09, 5'h06},
      '{1'b0, 3'h2, 5'h0d, 5'h0a}, '{1'b1, 3'h3, 5'h11, 5'h0e}, '{1'b0, 3'h4, 5'h15, 5'h12},
      '{1'b1, 3'h5, 5'h15, 5'h16}, '{1'b0, 3'h6, 5'h15, 5'h16}, '{1'b1, 3'h7, 5'h15, 5'h16}};
   pbfws_top dut (.*);
   pbfws_flash_model flash (.mclk_i(mclk_i), .addr_strobe_i(addr_strobe_o), .data_strobe_i(data_strobe_o),
      .bank_select_i(bank_select_o), .ad_waits_o(ad_waits), .bank_seen_o(bank_seen));
   always #10 mclk_i = ~mclk_i;
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
      @(posedge mclk_i);
      s_axi_awaddr_i <= a;
      s_axi_wdata_i <= d;
      s_axi_wstrb_i <= s;
      s_axi_awvalid_i <= 1'b1;
      s_axi_wvalid_i <= 1'b1;
      s_axi_bready_i <= 1'b1;
      do begin
         @(posedge mclk_i);
         if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
         if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
      end while (s_axi_bvalid_o !== 1'b1);
      s_axi_bready_i <= 1'b0;
      chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp_o});
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge mclk_i);
      s_axi_araddr_i <= a;
      s_axi_arvalid_i <= 1'b1;
      s_axi_rready_i <= 1'b1;
      do begin
         @(posedge mclk_i);
         if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
      end while (s_axi_rvalid_o !== 1'b1);
      s_axi_rready_i <= 1'b0;
      chk("rdata", d, s_axi_rdata_o);
      chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp_o});
   endtask
   // Total span from acceptance to ready again is N + M + 3 cycles
   task automatic acc(input logic b, input logic [4:0] n, input logic [4:0] m);
      int t;
      @(posedge mclk_i);
      req_valid_i <= 1'b1;
      req_bank_i <= b;
      do @(posedge mclk_i); while (req_ready_o !== 1'b1);
      req_valid_i <= 1'b0;
      t = 0;
      do begin
         @(posedge mclk_i);
         t++;
      end while (req_ready_o !== 1'b1);
      chk("span", {27'h0, n} + {27'h0, m} + 32'h3, t);
      chk("ad waits", {27'h0, n}, {24'h0, ad_waits});
      chk("bank", b ? 32'h2 : 32'h1, {30'h0, bank_seen});
   endtask
   task automatic wrap_up;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge mclk_i);
      reset_i <= 1'b0;
      rd(12'h000, 32'h1dc, 2'h0);
      rd(12'h004, 32'h1dc, 2'h0);
      for (int i = 0; i < 8; i++) begin
         wr({9'h0, rows[i].b, 2'h0}, {23'h0, rows[i].c, 1'b0, rows[i].c, 2'h0}, 4'hf, 2'h0);
         acc(rows[i].b, rows[i].n, rows[i].m);
      end
      // Mid-run reset: bank0 was left on a non-default profile
      @(posedge mclk_i);
      reset_i <= 1'b1;
      repeat (2) @(posedge mclk_i);
      reset_i <= 1'b0;
      chk("ready after reset", 32'h1, {31'h0, req_ready_o});
      rd(12'h000, 32'h1dc, 2'h0);
      rd(12'h004, 32'h1dc, 2'h0);
      rd(12'h00c, 32'h0, 2'h2);
      wr(12'h00c, 32'h1, 4'hf, 2'h2);
      wr(12'h008, 32'h0, 4'hf, 2'h0);
      // Banks differ on purpose so a shared field would show
      wr(12'h000, 32'h0, 4'hf, 2'h0);
      wr(12'h004, 32'hcc, 4'hf, 2'h0);
      acc(1'b0, 5'h05, 5'h03);
      acc(1'b1, 5'h11, 5'h0e);
      wr(12'h004, 32'hffffffff, 4'h1, 2'h0);
      rd(12'h004, 32'hff, 2'h0);
      acc(1'b1, 5'h15, 5'h0e);
      wrap_up;
   end
   initial begin
      #100us;
      mismatches++;
      wrap_up;
   end
endmodule
